// ---- verilog/bpp_defs.svh ----
// Purpose: Shared constants for the battery pack protection controller.
// Assumes: A 20 MHz system clock.
// Notes:   Times keep their own units; tick counts derive from them.
`ifndef BPP_DEFS_SVH
`define BPP_DEFS_SVH

////////////////////////////////////////////////////////////////////////
`define BPP_CLK_HZ          20000000
`define BPP_TICK_US         50
`define BPP_TICK_CYCLES     ((`BPP_TICK_US * `BPP_CLK_HZ) / 1000000)
`define BPP_STANDBY_MS      79
`define BPP_STANDBY_TICKS   ((`BPP_STANDBY_MS * 1000) / `BPP_TICK_US)
`define BPP_SAMPLE_US       500
`define BPP_SAMPLE_TICKS    (`BPP_SAMPLE_US / `BPP_TICK_US)
`define BPP_CURRENT_DLY_MS  3
`define BPP_CURRENT_TICKS   ((`BPP_CURRENT_DLY_MS * 1000) / `BPP_TICK_US)
`define BPP_SHORT_DLY_US    450
`define BPP_SHORT_TICKS     (`BPP_SHORT_DLY_US / `BPP_TICK_US)
`define BPP_RUN_LEN         3'h4

////////////////////////////////////////////////////////////////////////
`define BPP_CTRL_ADDR       4'h0
`define BPP_STATUS_ADDR     4'h4
`define BPP_CTRL_RESET      1'h0
`define BPP_ST_MODE_LSB     0
`define BPP_ST_CHG_FAULT    2
`define BPP_ST_DIS_FAULT    3
`define BPP_ST_SHORT_FAULT  4
`define BPP_ST_OV_TRIP      5
`define BPP_ST_UV_SEEN      6
`define BPP_ST_OV_CNT_LSB   8
`define BPP_ST_UV_CNT_LSB   12
`define BPP_ST_TRICKLE_N    16
`define BPP_ST_FAST_N       17
`define BPP_ST_DISCH_N      18

`endif

// ---- verilog/bpp_pkg.sv ----
// Purpose: Types of the battery pack protection controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Mode codes follow declaration order from zero: shutdown 0, standby 1, sample 2.
package bpp_pkg;

  typedef enum logic [1:0] {
    BPP_SHUTDOWN,
    BPP_STANDBY,
    BPP_SAMPLE
  } bpp_mode_t;

endpackage

// ---- verilog/bpp_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are slow levels from comparators and pins.
// Notes:   Only the second stage may be read.
`timescale 1ns/1ns

module bpp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ---- verilog/bpp_qual_timer.sv ----
// Purpose: Qualification timer for a fault indication.
// Assumes: The tick is a one-cycle enable from the shared timebase.
// Notes:   Expires on the tick after LIMIT ticks of steady indication.
`timescale 1ns/1ns

module bpp_qual_timer #(
  parameter int CW    = 8,
  parameter int LIMIT = 60
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Timebase and indication.
  input  wire logic tick,
  input  wire logic active,
  // Result.
  output logic      expired
);

  localparam logic [CW-1:0] LAST = CW'(LIMIT);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !active) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (tick) begin
      if (cnt_reg == LAST) begin
        expired <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// ---- verilog/bpp_protect.sv ----
// Purpose: Sequencing and fault logic of a multi-cell pack protector.
// Assumes: Comparator flags and control pins are asynchronous levels.
// Notes:   Gate drives are active low; high turns a MOSFET off.
//
// Overview of operation
// - Force-off input holds all three gates off.
// - Sleep request turns all gates off; it shuts down only without a charger.
// - No fault: all three gates driven on.
// - Shutdown on sleep or undervoltage, no charger.
// - Leave shutdown on charger and supply above lockout.
// - Standby after shutdown, fixed interval, then sample.
// - Sample checks cells, fixed length, back to standby.
// - Current faults watched in standby and sample.
// - Four overvoltage samples turn charge gates off.
// - Clean sample restores charge gates after overvoltage.
// - Four undervoltage samples, no charger: all off, shutdown.
// - Undervoltage with charger: only trickle gate on.
// - No undervoltage sample: all gates on.
// - Qualified charge overcurrent turns charge gates off.
// - Charge fault latched until discharge flow seen.
// - Qualified discharge overcurrent turns all gates off.
// - Discharge fault latched until charger applied.
// - Qualified pack short turns all gates off.
// - Short fault latched until charger applied.
// - Force-off pin affects outputs only; sleep request also forces shutdown without a charger.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "bpp_defs.svh"

module bpp_protect #(
  parameter int TICK_CYCLES   = `BPP_TICK_CYCLES,
  parameter int STANDBY_TICKS = `BPP_STANDBY_TICKS,
  parameter int SAMPLE_TICKS  = `BPP_SAMPLE_TICKS,
  parameter int CURRENT_TICKS = `BPP_CURRENT_TICKS,
  parameter int SHORT_TICKS   = `BPP_SHORT_TICKS
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Control pins.
  input  wire logic        gate_force_off_input,
  input  wire logic        sleep_request_input,
  // Comparator flags.
  input  wire logic        charger_detect,
  input  wire logic        discharge_flow_detect,
  input  wire logic        supply_above_lockout,
  input  wire logic        cell_above_high_limit,
  input  wire logic        cell_below_low_limit,
  input  wire logic        current_above_charge_limit,
  input  wire logic        current_above_discharge_limit,
  input  wire logic        current_above_short_limit,
  // Gate drives, active low.
  output logic             trickle_gate_drive_n,
  output logic             fast_charge_gate_drive_n,
  output logic             discharge_gate_drive_n,
  // Sampling window for the cell front end.
  output logic             sample_window,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  import bpp_pkg::*;

  localparam int TW = 16;
  localparam int PW = 16;
  localparam int QW = 8;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [PW-1:0] STBY_LAST = PW'(STANDBY_TICKS - 1);
  localparam logic [PW-1:0] SMPL_LAST = PW'(SAMPLE_TICKS - 1);

  function automatic logic [2:0] run_step(input logic [2:0] cnt, input logic hit);
    if (!hit) begin
      run_step = 3'h0;
    end else if (cnt == `BPP_RUN_LEN) begin
      run_step = cnt;
    end else begin
      run_step = cnt + 3'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  logic [9:0] pins_s;
  logic       force_off_s;
  logic       sleep_req_s;
  logic       charger_s;
  logic       dis_flow_s;
  logic       supply_ok_s;
  logic       cell_hi_s;
  logic       cell_lo_s;
  logic       chg_cur_s;
  logic       dis_cur_s;
  logic       short_cur_s;

  bpp_sync #(
    .WIDTH (10)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({gate_force_off_input, sleep_request_input, charger_detect,
                discharge_flow_detect, supply_above_lockout, cell_above_high_limit,
                cell_below_low_limit, current_above_charge_limit,
                current_above_discharge_limit, current_above_short_limit}),
    .sync_out (pins_s)
  );

  assign {force_off_s, sleep_req_s, charger_s, dis_flow_s, supply_ok_s,
          cell_hi_s, cell_lo_s, chg_cur_s, dis_cur_s, short_cur_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////
  // Shared timebase.
  logic [TW-1:0] tick_cnt_reg;
  logic          tick_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing.
  bpp_mode_t     mode_reg;
  logic [PW-1:0] phase_reg;
  logic [2:0]    ov_cnt_reg;
  logic [2:0]    uv_cnt_reg;
  logic          uv_seen_reg;
  logic          normal;
  logic          sample_done;
  logic          go_sleep;

  assign normal      = (mode_reg != BPP_SHUTDOWN);
  assign sample_done = (mode_reg == BPP_SAMPLE) && tick_reg && (phase_reg == SMPL_LAST);
  assign go_sleep    = normal && !charger_s &&
                       (sleep_req_s || (uv_cnt_reg == `BPP_RUN_LEN));

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg  <= BPP_SHUTDOWN;
      phase_reg <= '0;
    end else if (go_sleep) begin
      mode_reg  <= BPP_SHUTDOWN;
      phase_reg <= '0;
    end else begin
      unique case (mode_reg)
        BPP_SHUTDOWN: begin
          if (charger_s && supply_ok_s) begin
            mode_reg  <= BPP_STANDBY;
            phase_reg <= '0;
          end
        end
        BPP_STANDBY: begin
          if (tick_reg) begin
            if (phase_reg == STBY_LAST) begin
              mode_reg  <= BPP_SAMPLE;
              phase_reg <= '0;
            end else begin
              phase_reg <= phase_reg + 1'b1;
            end
          end
        end
        BPP_SAMPLE: begin
          if (sample_done) begin
            mode_reg  <= BPP_STANDBY;
            phase_reg <= '0;
          end else if (tick_reg) begin
            phase_reg <= phase_reg + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cell sample run counters.
  always_ff @(posedge clk) begin
    if (rst || !normal) begin
      ov_cnt_reg  <= 3'h0;
      uv_cnt_reg  <= 3'h0;
      uv_seen_reg <= 1'b0;
    end else if (sample_done) begin
      ov_cnt_reg  <= run_step(ov_cnt_reg, cell_hi_s);
      uv_cnt_reg  <= run_step(uv_cnt_reg, cell_lo_s);
      uv_seen_reg <= cell_lo_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Current fault qualification and latches.
  logic chg_exp;
  logic dis_exp;
  logic short_exp;
  logic chg_fault_reg;
  logic dis_fault_reg;
  logic short_fault_reg;

  bpp_qual_timer #(
    .CW    (QW),
    .LIMIT (CURRENT_TICKS)
  ) u_chg_timer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_reg),
    .active  (normal && chg_cur_s),
    .expired (chg_exp)
  );

  bpp_qual_timer #(
    .CW    (QW),
    .LIMIT (CURRENT_TICKS)
  ) u_dis_timer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_reg),
    .active  (normal && dis_cur_s),
    .expired (dis_exp)
  );

  bpp_qual_timer #(
    .CW    (QW),
    .LIMIT (SHORT_TICKS)
  ) u_short_timer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_reg),
    .active  (normal && short_cur_s),
    .expired (short_exp)
  );

  // Set wins over clear on each latch.
  always_ff @(posedge clk) begin
    if (rst) begin
      chg_fault_reg <= 1'b0;
    end else if (chg_exp) begin
      chg_fault_reg <= 1'b1;
    end else if (dis_flow_s) begin
      chg_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dis_fault_reg <= 1'b0;
    end else if (dis_exp) begin
      dis_fault_reg <= 1'b1;
    end else if (charger_s) begin
      dis_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      short_fault_reg <= 1'b0;
    end else if (short_exp) begin
      short_fault_reg <= 1'b1;
    end else if (charger_s) begin
      short_fault_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate drive.
  logic ctrl_force_reg;
  logic ov_trip;
  logic uv_chg;
  logic all_off;

  assign ov_trip = (ov_cnt_reg == `BPP_RUN_LEN);
  assign uv_chg  = uv_seen_reg && charger_s;
  // Force-off only masks the drives; sleep request also feeds go_sleep, which sets shutdown.
  assign all_off = force_off_s || ctrl_force_reg || sleep_req_s || !normal ||
                   dis_fault_reg || short_fault_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      trickle_gate_drive_n     <= 1'b1;
      fast_charge_gate_drive_n <= 1'b1;
      discharge_gate_drive_n   <= 1'b1;
      sample_window            <= 1'b0;
    end else begin
      trickle_gate_drive_n     <= all_off || ov_trip || chg_fault_reg;
      fast_charge_gate_drive_n <= all_off || ov_trip || chg_fault_reg || uv_chg;
      discharge_gate_drive_n   <= all_off || uv_chg;
      sample_window            <= (mode_reg == BPP_SAMPLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register slave.
  logic req;
  logic [31:0] status;

  assign req = avs_read || avs_write;

  always_comb begin
    status = 32'h0;
    status[`BPP_ST_MODE_LSB +: 2]   = mode_reg;
    status[`BPP_ST_CHG_FAULT]       = chg_fault_reg;
    status[`BPP_ST_DIS_FAULT]       = dis_fault_reg;
    status[`BPP_ST_SHORT_FAULT]     = short_fault_reg;
    status[`BPP_ST_OV_TRIP]         = ov_trip;
    status[`BPP_ST_UV_SEEN]         = uv_seen_reg;
    status[`BPP_ST_OV_CNT_LSB +: 3] = ov_cnt_reg;
    status[`BPP_ST_UV_CNT_LSB +: 3] = uv_cnt_reg;
    status[`BPP_ST_TRICKLE_N]       = trickle_gate_drive_n;
    status[`BPP_ST_FAST_N]          = fast_charge_gate_drive_n;
    status[`BPP_ST_DISCH_N]         = discharge_gate_drive_n;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        `BPP_CTRL_ADDR:   avs_readdata <= {31'h0, ctrl_force_reg};
        `BPP_STATUS_ADDR: avs_readdata <= status;
        default:          avs_readdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_force_reg <= `BPP_CTRL_RESET;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
                 avs_address == `BPP_CTRL_ADDR) begin
      ctrl_force_reg <= avs_writedata[0];
    end
  end

endmodule

// ---- verification/bpp_pack_model.sv ----
// Purpose: Pack, charger and MOSFET model facing the protector.
// Assumes: Gate drives are active low.
// Notes:   Current flows only through a MOSFET that is on.
`timescale 1ns/1ns

module bpp_pack_model (
  // Bench controls.
  input  wire logic chg_on,
  input  wire logic supply_ok,
  input  wire logic cell_hi,
  input  wire logic cell_lo,
  input  wire logic i_chg,
  input  wire logic i_dis,
  input  wire logic i_short,
  // Gate drives.
  input  wire logic fast_charge_gate_drive_n,
  input  wire logic discharge_gate_drive_n,
  // Comparator flags.
  output logic      charger_detect,
  output logic      discharge_flow_detect,
  output logic      supply_above_lockout,
  output logic      cell_above_high_limit,
  output logic      cell_below_low_limit,
  output logic      current_above_charge_limit,
  output logic      current_above_discharge_limit,
  output logic      current_above_short_limit
);
  assign charger_detect = chg_on;
  assign discharge_flow_detect = !chg_on;
  assign supply_above_lockout = supply_ok;
  assign cell_above_high_limit = cell_hi;
  assign cell_below_low_limit = cell_lo;
  assign current_above_charge_limit = i_chg & chg_on & !fast_charge_gate_drive_n;
  assign current_above_discharge_limit = (i_dis | i_short) & !discharge_gate_drive_n;
  assign current_above_short_limit = i_short & !discharge_gate_drive_n;
endmodule

// ---- verification/bpp_protect_sva.sv ----
// Purpose: Port checker of the pack protector.
// Assumes: Bound to the top module.
// Notes:   Sample runs are counted at the fall of the window.
`timescale 1ns/1ns

module bpp_protect_sva #(
  parameter int TICK_CYCLES   = 1000,
  parameter int CURRENT_TICKS = 60,
  parameter int SHORT_TICKS   = 9
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Inputs.
  input wire logic gate_force_off_input,
  input wire logic sleep_request_input,
  input wire logic charger_detect,
  input wire logic cell_above_high_limit,
  input wire logic cell_below_low_limit,
  input wire logic current_above_charge_limit,
  input wire logic current_above_discharge_limit,
  input wire logic current_above_short_limit,
  // Outputs.
  input wire logic trickle_gate_drive_n,
  input wire logic fast_charge_gate_drive_n,
  input wire logic discharge_gate_drive_n,
  input wire logic sample_window
);
  localparam int CUR_LIM = (CURRENT_TICKS + 1) * TICK_CYCLES + 6;
  localparam int SHT_LIM = (SHORT_TICKS + 1) * TICK_CYCLES + 6;
  logic [15:0] chg_c, dis_c, sht_c;
  logic [2:0] ov_r, uv_r;
  logic       sw_q, fall, all_off;
  assign fall = sw_q & !sample_window;
  assign all_off = trickle_gate_drive_n & fast_charge_gate_drive_n & discharge_gate_drive_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  function automatic logic [15:0] inc(input logic [15:0] c);
    return (c == 16'hFFFF) ? c : c + 16'h0001;
  endfunction

  always_ff @(posedge clk) begin
    chg_c <= (rst || !current_above_charge_limit) ? 16'h0000 : inc(chg_c);
    dis_c <= (rst || !current_above_discharge_limit) ? 16'h0000 : inc(dis_c);
    sht_c <= (rst || !current_above_short_limit) ? 16'h0000 : inc(sht_c);
  end

  always_ff @(posedge clk) begin
    sw_q <= sample_window;
    if (rst) begin
      ov_r <= 3'h0;
    end else if (fall) begin
      ov_r <= cell_above_high_limit ? ov_r + 3'h1 : 3'h0;
    end
    if (rst || charger_detect) begin
      uv_r <= 3'h0;
    end else if (fall) begin
      uv_r <= cell_below_low_limit ? uv_r + 3'h1 : 3'h0;
    end
  end

  ////////////////////////////////////////
  force_off_a: assert property (gate_force_off_input [*4] |-> all_off)
    else $error("gate on while force-off held");
  sleep_off_a: assert property (sleep_request_input [*4] |-> all_off)
    else $error("gate on while sleep requested");
  sample_len_a: assert property ($rose(sample_window) |-> ##[7:9] !sample_window)
    else $error("sample window too long");
  standby_len_a: assert property ($fell(sample_window) |-> (!sample_window throughout (1'b1 ##17 1'b1)))
    else $error("standby too short");
  chg_fault_a: assert property (chg_c >= CUR_LIM |-> trickle_gate_drive_n && fast_charge_gate_drive_n)
    else $error("charge overcurrent not tripped");
  dis_fault_a: assert property (dis_c >= CUR_LIM |-> all_off)
    else $error("discharge overcurrent not tripped");
  short_fault_a: assert property (sht_c >= SHT_LIM |-> all_off)
    else $error("pack short not tripped");
  ov_trip_a: assert property (fall && cell_above_high_limit && ov_r == 3'h3 |-> ##[0:3]
    (trickle_gate_drive_n && fast_charge_gate_drive_n)) else $error("overvoltage run not tripped");
  uv_shut_a: assert property (fall && cell_below_low_limit && uv_r == 3'h3 |-> ##[0:3] all_off)
    else $error("undervoltage run not tripped");
endmodule

// ---- verification/bpp_protect_tb_top.sv ----
// Purpose: Self-checking bench of the pack protector.
// Assumes: Shortened timebase parameters.
// Notes:   Gate vector order is trickle, fast, discharge.
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module bpp_protect_tb_top;
  import bpp_pkg::*;
  logic        clk, rst, gate_force_off_input, sleep_request_input;
  logic        chg_on, supply_ok, cell_hi, cell_lo, i_chg, i_dis, i_short;
  logic        charger_detect, discharge_flow_detect, supply_above_lockout;
  logic        cell_above_high_limit, cell_below_low_limit, current_above_charge_limit;
  logic        current_above_discharge_limit, current_above_short_limit, sample_window;
  logic        trickle_gate_drive_n, fast_charge_gate_drive_n, discharge_gate_drive_n;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  gates;
  int          errors, checks;
  assign gates = {trickle_gate_drive_n, fast_charge_gate_drive_n, discharge_gate_drive_n};

  bpp_protect #(.TICK_CYCLES(4), .STANDBY_TICKS(5), .SAMPLE_TICKS(2), .CURRENT_TICKS(3), .SHORT_TICKS(2))
    bpp_protect_inst (.*);
  bpp_pack_model bpp_pack_model_inst (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic exp_g(input logic [2:0] e, input int n);
    @(negedge clk);
    while (n > 0 && gates !== e) begin
      @(negedge clk);
      n--;
    end
    `CHK(gates, e)
  endtask

  task automatic samples(input int n);
    int   k;
    logic t;
    k = 0;
    t = 1'b1;
    @(negedge clk);
    repeat (2 * n) begin
      while (sample_window !== t && k < 500) begin
        @(negedge clk);
        k++;
      end
      t = !t;
    end
    if (k >= 500) begin
      $display("MISMATCH %0t sample window timeout", $time);
      errors++;
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 20) begin
      $display("MISMATCH %0t bus timeout", $time);
      errors++;
      final_report();
    end
  endtask

  ////////////////////////////////////////
  task automatic t_wake();
    exp_g(3'h7, 0);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q[1:0], BPP_SHUTDOWN)
    @(posedge clk) chg_on <= 1'b1;
    cyc(20);
    exp_g(3'h7, 0);
    @(posedge clk) supply_ok <= 1'b1;
    exp_g(3'h0, 8);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q[1:0], BPP_STANDBY)
    bus(1'b1, 4'hC, 32'h1);
    cyc(4);
    exp_g(3'h0, 0);
    bus(1'b1, 4'h0, 32'h1);
    exp_g(3'h7, 6);
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q[0], 1'b1)
    bus(1'b1, 4'h0, 32'h0);
    exp_g(3'h0, 6);
  endtask

  task automatic t_cells();
    samples(1);
    @(posedge clk) cell_hi <= 1'b1;
    samples(3);
    @(posedge clk) cell_hi <= 1'b0;
    samples(1);
    @(posedge clk) cell_hi <= 1'b1;
    samples(3);
    cyc(4);
    exp_g(3'h0, 0);
    samples(1);
    exp_g(3'h6, 4);
    @(posedge clk) cell_hi <= 1'b0;
    samples(1);
    exp_g(3'h0, 4);
    @(posedge clk) cell_lo <= 1'b1;
    samples(1);
    exp_g(3'h3, 4);
    @(posedge clk) cell_lo <= 1'b0;
    samples(1);
    exp_g(3'h0, 4);
  endtask

  task automatic t_chg_fault();
    @(posedge clk) i_chg <= 1'b1;
    exp_g(3'h6, 40);
    @(posedge clk) i_chg <= 1'b0;
    samples(1);
    exp_g(3'h6, 0);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(q[2], 1'b1)
    @(posedge clk) gate_force_off_input <= 1'b1;
    exp_g(3'h7, 6);
    @(posedge clk) gate_force_off_input <= 1'b0;
    exp_g(3'h6, 6);
    @(posedge clk) chg_on <= 1'b0;
    exp_g(3'h0, 8);
  endtask

  task automatic t_dis_fault();
    repeat (2) begin
      @(posedge clk) i_dis <= 1'b1;
      cyc(10);
      @(posedge clk) i_dis <= 1'b0;
    end
    cyc(6);
    exp_g(3'h0, 0);
    @(posedge clk) i_dis <= 1'b1;
    exp_g(3'h7, 40);
    @(posedge clk) i_dis <= 1'b0;
    cyc(40);
    exp_g(3'h7, 0);
    @(posedge clk) chg_on <= 1'b1;
    exp_g(3'h0, 8);
    @(posedge clk) chg_on <= 1'b0;
    cyc(8);
    @(posedge clk) i_short <= 1'b1;
    exp_g(3'h7, 30);
    @(posedge clk) i_short <= 1'b0;
    cyc(40);
    exp_g(3'h7, 0);
    @(posedge clk) chg_on <= 1'b1;
    exp_g(3'h0, 8);
  endtask

  task automatic t_sleep();
    @(posedge clk) sleep_request_input <= 1'b1;
    exp_g(3'h7, 6);
    @(posedge clk) sleep_request_input <= 1'b0;
    exp_g(3'h0, 6);
    @(posedge clk) chg_on <= 1'b0;
    @(posedge clk) sleep_request_input <= 1'b1;
    exp_g(3'h7, 6);
    @(posedge clk) sleep_request_input <= 1'b0;
    cyc(40);
    exp_g(3'h7, 0);
    @(posedge clk) chg_on <= 1'b1;
    exp_g(3'h0, 8);
    @(posedge clk) chg_on <= 1'b0;
    samples(1);
    @(posedge clk) cell_lo <= 1'b1;
    samples(4);
    exp_g(3'h7, 4);
    @(posedge clk) cell_lo <= 1'b0;
    cyc(40);
    exp_g(3'h7, 0);
  endtask

  initial begin
    {rst, gate_force_off_input, sleep_request_input, chg_on, supply_ok} = 5'h10;
    {cell_hi, cell_lo, i_chg, i_dis, i_short} = 5'h00;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    errors = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_wake();
    t_cells();
    t_chg_fault();
    t_dis_fault();
    t_sleep();
    final_report();
  end
endmodule

bind bpp_protect bpp_protect_sva #(.TICK_CYCLES(TICK_CYCLES), .CURRENT_TICKS(CURRENT_TICKS),
  .SHORT_TICKS(SHORT_TICKS)) bpp_protect_sva_inst (.*);
